//--- shared/cie_alu_if.sv
// operand and result bundle between the core and its alu
`timescale 1ns/1ps
interface cie_alu_if;
   import cie_pkg::*;
   cie_aop_t op;
   logic [7:0] a;
   logic [7:0] b;
   logic [2:0] bsel;
   logic cin;
   logic [7:0] res;
   logic cout;
   modport core (output op, a, b, bsel, cin, input res, cout);
   modport alu (input op, a, b, bsel, cin, output res, cout);
endinterface : cie_alu_if

//--- shared/cie_consts.svh
// constants of the instruction execution and timing block
`ifndef CIE_CONSTS_SVH
`define CIE_CONSTS_SVH
`define CIE_ICYC_CLKS 4
`define CIE_PC_W 11
`define CIE_PC_RST 11'h000
`define CIE_PCL_ADDR 8'h02
`define CIE_TBL_PAGE 3'h7
`define CIE_IR_OP_MSB 15
`define CIE_IR_OP_LSB 11
`define CIE_IR_BIT_MSB 10
`define CIE_IR_BIT_LSB 8
`define CIE_IR_ARG_MSB 7
`define CIE_IR_ARG_LSB 0
`define CIE_IR_TGT_MSB 10
`define CIE_IR_NOP 16'h0000
`endif

//--- shared/cie_pkg.sv
// types of the instruction execution and timing block
package cie_pkg;
   // one-hot system clock phase inside an instruction cycle
   typedef enum logic [3:0] {
      PH_T1 = 4'h1,
      PH_T2 = 4'h2,
      PH_T3 = 4'h4,
      PH_T4 = 4'h8
   } cie_ph_t;

   // instruction classes held in the opcode field
   typedef enum logic [4:0] {
      OP_NOP = 5'h00, OP_MOVE_A_M, OP_MOVE_M_A, OP_MOVE_A_X,
      OP_ADD_M, OP_ADD_X, OP_SUB_M, OP_SUB_X, OP_AND, OP_OR, OP_XOR,
      OP_COMPLEMENT, OP_COMPLEMENT_TO_ACC, OP_INCREMENT,
      OP_INCREMENT_TO_ACC, OP_DECREMENT, OP_DECREMENT_TO_ACC,
      OP_ROTATE_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT_CARRY,
      OP_ROTATE_LEFT_CARRY, OP_BIT_SET, OP_BIT_CLEAR, OP_SKIP_ZERO,
      OP_SKIP_BIT_ZERO, OP_UNCOND_JUMP, OP_CALL, OP_SUB_RETURN,
      OP_INT_RETURN, OP_TABLE_READ, OP_HALT
   } cie_op_t;

   // operations of the arithmetic and logic unit
   typedef enum logic [3:0] {
      A_ADD, A_SUB, A_AND, A_OR, A_XOR, A_NOT, A_INC, A_DECR,
      A_ROR, A_ROL, A_RORC, A_ROLC, A_PASS, A_PASSA, A_BSET, A_BCLR
   } cie_aop_t;

   // decoded controls of one instruction
   typedef struct packed {
      cie_aop_t aop;
      logic imm;
      logic wr_acc;
      logic wr_mem;
      logic upd_z;
      logic upd_c;
   } cie_dec_t;
endpackage : cie_pkg

//--- verification/cie_mem_model.sv
// program and data memory model beside the core
`timescale 1ns/1ps
`include "cie_consts.svh"
module cie_mem_model #(
   parameter int PM_LAG = 2
) (
   input wire logic i_sys_clk,
   input wire logic [`CIE_PC_W-1:0] i_pm_addr,
   output logic [15:0] o_pm_data,
   input wire logic [7:0] i_dm_addr,
   input wire logic [7:0] i_dm_wdata,
   input wire logic i_dm_we,
   output logic [7:0] o_dm_rdata
);
   logic [15:0] pm [0:(1<<`CIE_PC_W)-1];
   logic [7:0] dm [0:255];
   logic [`CIE_PC_W-1:0] last_addr = '0;
   int lag = 0;

   // ***************************************************
   // slow program memory
   // ***************************************************
   // a fresh address shows inverted junk, so early samples go wrong
   always @(posedge i_sys_clk) begin
      last_addr <= i_pm_addr;
      lag <= (i_pm_addr !== last_addr) ? 1 : lag + 1;
   end
   assign o_pm_data = (i_pm_addr !== last_addr || lag < PM_LAG) ?
                      ~pm[i_pm_addr] : pm[i_pm_addr];

   // ***************************************************
   // data memory
   // ***************************************************
   // every strobe lands, so a stray write to the counter byte shows
   always @(posedge i_sys_clk) begin
      if (i_dm_we === 1'b1) begin
         dm[i_dm_addr] <= i_dm_wdata;
      end
   end
   assign o_dm_rdata = dm[i_dm_addr]; // combinational read
endmodule : cie_mem_model

//--- verification/mcu_instruction_execution_timing_tb.sv
// self-checking bench of the instruction timing core
`timescale 1ns/1ps
`include "cie_consts.svh"
module mcu_instruction_execution_timing_tb;
   import cie_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_wake = 1'b0;
   logic i_gie_clr = 1'b0;
   logic [`CIE_PC_W-1:0] pm_addr;
   logic [15:0] pm_data;
   logic [7:0] dm_addr, dm_wdata, dm_rdata, acc;
   logic dm_we, carry, zero, gie, halted, icyc_end;
   cie_ph_t phase;
   int n_fail = 0;
   int n_tests = 0;
   int base_ic, base_clk, cyc;

   // ***************************************************
   // clock, design and memories
   // ***************************************************
   initial begin
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   cie_core #(.STK_DEPTH(8)) uut (.i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn), .o_pm_addr(pm_addr), .i_pm_data(pm_data),
      .o_dm_addr(dm_addr), .o_dm_wdata(dm_wdata), .o_dm_we(dm_we),
      .i_dm_rdata(dm_rdata), .i_wake(i_wake), .i_gie_clr(i_gie_clr),
      .o_acc(acc), .o_carry(carry), .o_zero(zero), .o_gie(gie),
      .o_halted(halted), .o_icycle_end(icyc_end), .o_phase(phase));
   cie_mem_model #(.PM_LAG(2)) mdl (.i_sys_clk(i_sys_clk),
      .i_pm_addr(pm_addr), .o_pm_data(pm_data), .i_dm_addr(dm_addr),
      .i_dm_wdata(dm_wdata), .i_dm_we(dm_we), .o_dm_rdata(dm_rdata));

   // ***************************************************
   // checking helpers
   // ***************************************************
   task automatic stop_test;
      $display("tests %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // hang guard, far above the whole run
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         stop_test();
      end
   end

   task automatic chk8(string nm, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk8

   task automatic chk_n(string nm, int exp, int got);
      n_tests++;
      if (got != exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chk_n

   function automatic logic [15:0] enc(cie_op_t op, logic [7:0] a = 8'h00,
                                       logic [2:0] b = 3'h0);
      return {op, b, a};
   endfunction : enc

   // wipe both memories; an all-zero word is a no-operation
   task automatic clr_mem;
      for (int i = 0; i < (1 << `CIE_PC_W); i++) mdl.pm[i] = 16'h0000;
      for (int i = 0; i < 256; i++) mdl.dm[i] = 8'h00;
   endtask : clr_mem

   // reset, then count cycles and clocks up to the halt
   task automatic run_prog(output int ic, output int nclk);
      i_rstn = 1'b0;
      repeat (3) @(negedge i_sys_clk);
      i_rstn = 1'b1;
      ic = 0;
      nclk = 0;
      while (halted !== 1'b1 && nclk < 400) begin
         @(negedge i_sys_clk);
         nclk++;
         if (icyc_end === 1'b1) ic++;
      end
   endtask : run_prog

   // cost against the bare halt program
   task automatic exec(string nm, int exp_ic);
      int ic, nclk;
      run_prog(ic, nclk);
      chk_n({nm, " cycles"}, exp_ic, ic - base_ic);
      chk_n({nm, " clocks"}, 4 * exp_ic, nclk - base_clk);
   endtask : exec

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_arith;
      clr_mem();
      mdl.pm[0] = enc(OP_MOVE_A_X, 8'hF0);
      mdl.pm[1] = enc(OP_ADD_X, 8'h20);
      mdl.pm[2] = enc(OP_MOVE_M_A, 8'h40);
      mdl.pm[3] = enc(OP_INCREMENT, 8'h40);
      mdl.pm[4] = enc(OP_DECREMENT_TO_ACC, 8'h40);
      mdl.pm[5] = enc(OP_SUB_M, 8'h40);
      mdl.pm[6] = enc(OP_HALT);
      exec("arith", 6);
      chk8("acc", 8'hFF, acc);
      chk8("borrow", 8'h01, 8'(carry));
      chk8("mem inc", 8'h11, mdl.dm[8'h40]);
      $display("test arith done");
   endtask : t_arith

   task automatic t_logic;
      cie_op_t ops [4] = '{OP_AND, OP_OR, OP_XOR, OP_COMPLEMENT_TO_ACC};
      logic [7:0] mv [4] = '{8'h0F, 8'h0F, 8'h0F, 8'hFF};
      logic [7:0] av [4] = '{8'hF0, 8'hF0, 8'h0F, 8'h12};
      logic [7:0] ev [4] = '{8'h00, 8'hFF, 8'h00, 8'h00};
      for (int i = 0; i < 4; i++) begin
         clr_mem();
         mdl.pm[0] = enc(OP_MOVE_A_X, mv[i]);
         mdl.pm[1] = enc(OP_MOVE_M_A, 8'h41);
         mdl.pm[2] = enc(OP_MOVE_A_X, av[i]);
         mdl.pm[3] = enc(ops[i], 8'h41);
         mdl.pm[4] = enc(OP_HALT);
         exec("logic", 4);
         chk8("logic acc", ev[i], acc);
         chk8("logic zero", 8'(ev[i] == 8'h00), 8'(zero));
      end
      $display("test logic done");
   endtask : t_logic

   task automatic t_rotate;
      cie_op_t ops [4] = '{OP_ROTATE_RIGHT, OP_ROTATE_LEFT,
                           OP_ROTATE_RIGHT_CARRY, OP_ROTATE_LEFT_CARRY};
      logic [7:0] ev [4] = '{8'h40, 8'h01, 8'hC0, 8'h01};
      logic ec [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++) begin
         clr_mem();
         mdl.pm[0] = enc(OP_MOVE_A_X, 8'hFF);
         mdl.pm[1] = enc(OP_ADD_X, 8'h01); // carry starts set
         mdl.pm[2] = enc(OP_MOVE_A_X, 8'h80);
         mdl.pm[3] = enc(OP_MOVE_M_A, 8'h42);
         mdl.pm[4] = enc(ops[i], 8'h42);
         mdl.pm[5] = enc(OP_HALT);
         exec("rotate", 5);
         chk8("rot mem", ev[i], mdl.dm[8'h42]);
         chk8("rot carry", 8'(ec[i]), 8'(carry));
      end
      $display("test rotate done");
   endtask : t_rotate

   task automatic t_bits;
      clr_mem();
      mdl.pm[0] = enc(OP_MOVE_A_X, 8'hA5);
      mdl.pm[1] = enc(OP_MOVE_M_A, 8'h43);
      mdl.pm[2] = enc(OP_BIT_SET, 8'h43, 3'h1);
      mdl.pm[3] = enc(OP_BIT_CLEAR, 8'h43, 3'h7);
      mdl.pm[4] = enc(OP_HALT);
      exec("bits", 4);
      chk8("bit mem", 8'h27, mdl.dm[8'h43]);
      $display("test bits done");
   endtask : t_bits

   task automatic t_skip;
      clr_mem();
      mdl.pm[0] = enc(OP_MOVE_A_X, 8'h08);
      mdl.pm[1] = enc(OP_MOVE_M_A, 8'h45);
      mdl.pm[2] = enc(OP_SKIP_ZERO, 8'h44); // taken
      mdl.pm[3] = enc(OP_MOVE_A_X, 8'h11);
      mdl.pm[4] = enc(OP_SKIP_BIT_ZERO, 8'h45, 3'h3); // not taken
      mdl.pm[5] = enc(OP_ADD_X, 8'h01);
      mdl.pm[6] = enc(OP_SKIP_BIT_ZERO, 8'h45, 3'h2); // taken
      mdl.pm[7] = enc(OP_ADD_X, 8'h40);
      mdl.pm[8] = enc(OP_HALT);
      exec("skip", 8);
      chk8("skip acc", 8'h09, acc);
      $display("test skip done");
   endtask : t_skip

   task automatic t_call;
      clr_mem();
      mdl.pm[0] = enc(OP_MOVE_A_X, 8'h01);
      mdl.pm[1] = enc(OP_CALL, 8'h10);
      mdl.pm[2] = enc(OP_ADD_X, 8'h02);
      mdl.pm[3] = enc(OP_UNCOND_JUMP, 8'h20);
      mdl.pm[4] = enc(OP_MOVE_A_X, 8'h55);
      mdl.pm[16] = enc(OP_ADD_X, 8'h04);
      mdl.pm[17] = enc(OP_SUB_RETURN);
      mdl.pm[32] = enc(OP_HALT);
      exec("call", 9);
      chk8("call acc", 8'h07, acc);
      chk8("ret gie", 8'h00, 8'(gie));
      $display("test call done");
   endtask : t_call

   task automatic t_iret;
      clr_mem();
      mdl.pm[0] = enc(OP_CALL, 8'h10);
      mdl.pm[1] = enc(OP_HALT);
      mdl.pm[16] = enc(OP_INT_RETURN);
      exec("iret", 4);
      chk8("iret gie", 8'h01, 8'(gie));
      i_gie_clr = 1'b1;
      @(negedge i_sys_clk);
      i_gie_clr = 1'b0;
      @(negedge i_sys_clk);
      chk8("gie clear", 8'h00, 8'(gie));
      $display("test iret done");
   endtask : t_iret

   task automatic t_pcl;
      clr_mem();
      mdl.pm[0] = enc(OP_MOVE_A_X, 8'h08);
      mdl.pm[1] = enc(OP_MOVE_M_A, `CIE_PCL_ADDR);
      mdl.pm[2] = enc(OP_MOVE_A_X, 8'h99);
      mdl.pm[8] = enc(OP_HALT);
      exec("pcl", 3);
      chk8("pcl acc", 8'h08, acc);
      chk8("pcl mem", 8'h00, mdl.dm[`CIE_PCL_ADDR]);
      $display("test pcl done");
   endtask : t_pcl

   task automatic t_table;
      clr_mem();
      mdl.pm[{3'h7, 8'h30}] = 16'hBEEF;
      mdl.pm[0] = enc(OP_MOVE_A_X, 8'h30);
      mdl.pm[1] = enc(OP_TABLE_READ, 8'h46);
      mdl.pm[2] = enc(OP_HALT);
      exec("table", 3);
      chk8("table mem", 8'hEF, mdl.dm[8'h46]);
      $display("test table done");
   endtask : t_table

   task automatic t_halt;
      int n;
      clr_mem();
      mdl.pm[0] = enc(OP_HALT);
      mdl.pm[1] = enc(OP_MOVE_A_X, 8'h5A);
      mdl.pm[2] = enc(OP_HALT);
      exec("halt", 0);
      repeat (12) @(negedge i_sys_clk);
      chk8("stay halted", 8'h01, 8'(halted));
      chk8("phase frozen", 8'(PH_T1), 8'(phase));
      chk8("acc in halt", 8'h00, acc);
      i_wake = 1'b1;
      n = 0;
      while (halted === 1'b1 && n < 40) begin
         @(negedge i_sys_clk);
         n++;
      end
      i_wake = 1'b0;
      while (halted !== 1'b1 && n < 80) begin
         @(negedge i_sys_clk);
         n++;
      end
      chk8("wake acc", 8'h5A, acc);
      $display("test halt done");
   endtask : t_halt

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      clr_mem();
      mdl.pm[0] = enc(OP_HALT);
      run_prog(base_ic, base_clk);
      chk8("reset gie", 8'h00, 8'(gie));
      t_arith();
      t_logic();
      t_rotate();
      t_bits();
      t_skip();
      t_call();
      t_iret();
      t_pcl();
      t_table();
      t_halt();
      stop_test();
   end
endmodule : mcu_instruction_execution_timing_tb

//--- verilog/cie_alu.sv
// combinational 8-bit arithmetic and logic unit of the core
`timescale 1ns/1ps
module cie_alu (
   cie_alu_if.alu bus
);
   import cie_pkg::*;

   logic [8:0] wide;
   logic [7:0] msk;

   // ********************************************************
   // result and carry out
   // ********************************************************
   // sub leaves bit 8 set when the result fell below zero
   always_comb begin
      wide = 9'h000;
      msk = 8'(8'h01 << bus.bsel);
      bus.res = bus.b;
      bus.cout = bus.cin;
      unique case (bus.op)
         A_ADD: begin
            wide = {1'b0, bus.a} + {1'b0, bus.b}; // [RULE6]
            bus.res = wide[7:0];
            bus.cout = wide[8];
         end
         A_SUB: begin
            wide = {1'b0, bus.a} - {1'b0, bus.b}; // [RULE6]
            bus.res = wide[7:0];
            bus.cout = wide[8];
         end
         A_AND: bus.res = bus.a & bus.b;
         A_OR: bus.res = bus.a | bus.b;
         A_XOR: bus.res = bus.a ^ bus.b;
         A_NOT: bus.res = ~bus.b;
         A_INC: bus.res = bus.b + 8'h01; // [RULE7]
         A_DECR: bus.res = bus.b - 8'h01; // [RULE7]
         A_ROR: bus.res = {bus.b[0], bus.b[7:1]}; // [RULE9]
         A_ROL: bus.res = {bus.b[6:0], bus.b[7]}; // [RULE9]
         A_RORC: begin
            bus.res = {bus.cin, bus.b[7:1]}; // [RULE9]
            bus.cout = bus.b[0];
         end
         A_ROLC: begin
            bus.res = {bus.b[6:0], bus.cin}; // [RULE9]
            bus.cout = bus.b[7];
         end
         A_PASS: bus.res = bus.b;
         A_PASSA: bus.res = bus.a;
         A_BSET: bus.res = bus.b | msk; // [RULE12]
         A_BCLR: bus.res = bus.b & ~msk; // [RULE12]
      endcase
   end
endmodule : cie_alu

//--- verilog/cie_core.sv
// instruction sequencing and timing of the 8-bit core
`timescale 1ns/1ps
`include "cie_consts.svh"

// Operation
// (RULE1) ordinary instructions take one instruction cycle
// (RULE2) jump, call, table read take two cycles
// (RULE3) one instruction cycle is four clocks
// (RULE4) writing program counter low byte jumps, costs one
// (RULE5) skip taken costs one extra cycle
// (RULE6) add reports carry, subtract reports borrow
// (RULE7) increment and decrement change operand by one
// (RULE8) logical results of zero set zero flag
// (RULE9) rotates move one bit, carry variants through carry
// (RULE10) call saves return point, return resumes after
// (RULE11) conditional skip tests byte or single bit
// (RULE12) bit set and clear touch one bit
// (RULE13) table read copies program memory into data
// (RULE14) halt instruction enters low-power halted state
// (RULE15) moves between register, accumulator, immediate
// (RULE16) interrupt return sets global interrupt enable
// (RULE17) extra cycle discards fetch, fetches from target
module cie_core #(
   parameter int STK_DEPTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   output logic [`CIE_PC_W-1:0] o_pm_addr,
   input wire logic [15:0] i_pm_data,
   output logic [7:0] o_dm_addr,
   output logic [7:0] o_dm_wdata,
   output logic o_dm_we,
   input wire logic [7:0] i_dm_rdata,
   input wire logic i_wake,
   input wire logic i_gie_clr,
   output logic [7:0] o_acc,
   output logic o_carry,
   output logic o_zero,
   output logic o_gie,
   output logic o_halted,
   output logic o_icycle_end,
   output cie_pkg::cie_ph_t o_phase
);
   import cie_pkg::*;

   localparam int SPW = (STK_DEPTH > 1) ? $clog2(STK_DEPTH) : 1;

   cie_ph_t ph_r;
   logic halt_r, flush_r, tbl_r, carry_r, zero_r, gie_r, we_r;
   logic [15:0] ir_r;
   logic [`CIE_PC_W-1:0] pc_r, pm_addr_r, pc_nxt, top, jtgt;
   logic [`CIE_PC_W-1:0] stk [STK_DEPTH];
   logic [SPW-1:0] sp_r;
   logic [7:0] acc_r, mdat_r, dm_addr_r, wdata_r, tdst_r, res_r;
   logic [7:0] arg, opb, mask, res;
   logic [8:0] add9;
   logic [2:0] bsel;
   logic t3, t4, exe, pcl_wr, skip, jump, add_cy;
   cie_op_t op;
   cie_dec_t dec;

   cie_alu_if alu_if ();
   cie_alu u_alu (.bus(alu_if.alu));

   // ********************************************************
   // decode
   // ********************************************************
   function automatic cie_dec_t decode(input cie_op_t o);
      cie_dec_t d;
      d = '{aop: A_PASS, imm: 1'b0, wr_acc: 1'b0, wr_mem: 1'b0,
            upd_z: 1'b0, upd_c: 1'b0};
      unique case (o)
         OP_MOVE_A_M: d.wr_acc = 1'b1; // [RULE15]
         OP_MOVE_M_A: begin
            d.aop = A_PASSA; // [RULE15]
            d.wr_mem = 1'b1;
         end
         OP_MOVE_A_X: begin
            d.imm = 1'b1; // [RULE15]
            d.wr_acc = 1'b1;
         end
         OP_ADD_M, OP_ADD_X, OP_SUB_M, OP_SUB_X: begin
            d.aop = (o == OP_ADD_M || o == OP_ADD_X) ? A_ADD : A_SUB;
            d.imm = (o == OP_ADD_X || o == OP_SUB_X);
            d.wr_acc = 1'b1;
            d.upd_z = 1'b1;
            d.upd_c = 1'b1; // [RULE6]
         end
         OP_AND, OP_OR, OP_XOR: begin
            d.aop = (o == OP_AND) ? A_AND : (o == OP_OR) ? A_OR : A_XOR;
            d.wr_acc = 1'b1;
            d.upd_z = 1'b1; // [RULE8]
         end
         OP_COMPLEMENT, OP_COMPLEMENT_TO_ACC: begin
            d.aop = A_NOT;
            d.wr_mem = (o == OP_COMPLEMENT);
            d.wr_acc = (o != OP_COMPLEMENT);
            d.upd_z = 1'b1; // [RULE8]
         end
         OP_INCREMENT, OP_INCREMENT_TO_ACC, OP_DECREMENT,
         OP_DECREMENT_TO_ACC: begin
            d.aop = (o == OP_INCREMENT || o == OP_INCREMENT_TO_ACC) ?
                    A_INC : A_DECR;
            d.wr_mem = (o == OP_INCREMENT || o == OP_DECREMENT); // [RULE7]
            d.wr_acc = !d.wr_mem;
            d.upd_z = 1'b1;
         end
         OP_ROTATE_RIGHT: begin
            d.aop = A_ROR; // [RULE9]
            d.wr_mem = 1'b1;
         end
         OP_ROTATE_LEFT: begin
            d.aop = A_ROL; // [RULE9]
            d.wr_mem = 1'b1;
         end
         OP_ROTATE_RIGHT_CARRY, OP_ROTATE_LEFT_CARRY: begin
            d.aop = (o == OP_ROTATE_RIGHT_CARRY) ? A_RORC : A_ROLC;
            d.wr_mem = 1'b1;
            d.upd_c = 1'b1; // [RULE9]
         end
         OP_BIT_SET, OP_BIT_CLEAR: begin
            d.aop = (o == OP_BIT_SET) ? A_BSET : A_BCLR; // [RULE12]
            d.wr_mem = 1'b1;
         end
         OP_NOP, OP_SKIP_ZERO, OP_SKIP_BIT_ZERO, OP_UNCOND_JUMP, OP_CALL,
         OP_SUB_RETURN, OP_INT_RETURN, OP_TABLE_READ, OP_HALT: ;
         default: ; // spare opcode runs as a no-operation
      endcase
      return d;
   endfunction : decode

   // field split and alu hookup
   assign op = cie_op_t'(ir_r[`CIE_IR_OP_MSB:`CIE_IR_OP_LSB]);
   assign dec = decode(op);
   assign arg = ir_r[`CIE_IR_ARG_MSB:`CIE_IR_ARG_LSB];
   assign bsel = ir_r[`CIE_IR_BIT_MSB:`CIE_IR_BIT_LSB];
   assign jtgt = ir_r[`CIE_IR_TGT_MSB:0];
   assign t3 = (ph_r == PH_T3);
   assign t4 = (ph_r == PH_T4);
   assign exe = !flush_r && !tbl_r;
   assign opb = dec.imm ? arg : mdat_r;
   assign alu_if.op = dec.aop;
   assign alu_if.a = acc_r;
   assign alu_if.b = opb;
   assign alu_if.bsel = bsel;
   assign alu_if.cin = carry_r;
   assign res = alu_if.res;
   assign top = stk[sp_r - 1'b1];
   assign mask = 8'(8'h01 << bsel);
   assign add9 = {1'b0, acc_r} + {1'b0, opb};
   assign add_cy = add9[8];
   assign pcl_wr = exe && dec.wr_mem && (arg == `CIE_PCL_ADDR);
   assign skip = exe && ((op == OP_SKIP_ZERO && mdat_r == 8'h00) || // [RULE11]
                 (op == OP_SKIP_BIT_ZERO && !mdat_r[bsel]));

   // next fetch address; any change of flow flushes the fetched word
   always_comb begin
      pc_nxt = pc_r + 1'b1;
      jump = 1'b0;
      if (exe && (op == OP_UNCOND_JUMP || op == OP_CALL)) begin
         pc_nxt = jtgt; // [RULE2]
         jump = 1'b1;
      end else if (exe && (op == OP_SUB_RETURN || op == OP_INT_RETURN)) begin
         pc_nxt = top; // [RULE10]
         jump = 1'b1;
      end else if (pcl_wr) begin
         pc_nxt = {pc_r[`CIE_PC_W-1:8], res_r}; // [RULE4]
         jump = 1'b1;
      end else if (skip) begin
         jump = 1'b1; // [RULE5]
      end
   end

   // ********************************************************
   // timing
   // ********************************************************
   // four clock phases per instruction cycle, frozen while halted
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ph_r <= PH_T1;
      end else if (!halt_r) begin
         unique case (ph_r)
            PH_T1: ph_r <= PH_T2; // [RULE3]
            PH_T2: ph_r <= PH_T3;
            PH_T3: ph_r <= PH_T4;
            PH_T4: ph_r <= PH_T1;
         endcase
      end
   end

   // halt: the fetched follower waits in the instruction register
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         halt_r <= 1'b0;
      end else if (halt_r && i_wake) begin
         halt_r <= 1'b0;
      end else if (t4 && exe && op == OP_HALT) begin
         halt_r <= 1'b1; // [RULE14]
      end
   end

   // ********************************************************
   // fetch and flow
   // ********************************************************
   // a flushed word runs as a bubble while the target is fetched
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ir_r <= `CIE_IR_NOP;
         pc_r <= `CIE_PC_RST;
         pm_addr_r <= `CIE_PC_RST;
         flush_r <= 1'b1;
         tbl_r <= 1'b0;
         tdst_r <= 8'h00;
      end else if (t4) begin
         if (tbl_r) begin
            tbl_r <= 1'b0; // table cycle keeps the instruction register
            pm_addr_r <= pc_r;
         end else begin
            ir_r <= i_pm_data;
            flush_r <= jump; // [RULE17] [RULE1]
            if (exe && op == OP_TABLE_READ) begin
               tbl_r <= 1'b1; // [RULE2] [RULE13]
               tdst_r <= arg;
               pc_r <= pc_r + 1'b1;
               pm_addr_r <= {`CIE_TBL_PAGE, acc_r};
            end else begin
               pc_r <= pc_nxt;
               pm_addr_r <= pc_nxt; // [RULE17]
            end
         end
      end
   end

   // return stack; overflow wraps, so deep nesting loses the oldest
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         sp_r <= '0;
      end else if (t4 && exe && op == OP_CALL) begin
         stk[sp_r] <= pc_r; // [RULE10]
         sp_r <= sp_r + 1'b1;
      end else if (t4 && exe && (op == OP_SUB_RETURN ||
                   op == OP_INT_RETURN)) begin
         sp_r <= sp_r - 1'b1;
      end
   end

   // ********************************************************
   // data path
   // ********************************************************
   // operand fetch; the low program counter byte is read internally
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         mdat_r <= 8'h00;
         res_r <= 8'h00;
      end else begin
         if (ph_r == PH_T2) begin
            mdat_r <= (dm_addr_r == `CIE_PCL_ADDR) ? pc_r[7:0] : i_dm_rdata;
         end
         if (t3) begin
            res_r <= res;
         end
      end
   end

   // data memory port: write strobe covers the fourth phase
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         dm_addr_r <= 8'h00;
         we_r <= 1'b0;
         wdata_r <= 8'h00;
      end else begin
         if (ph_r == PH_T1) begin
            dm_addr_r <= tbl_r ? tdst_r : arg;
         end
         if (t3 && tbl_r) begin
            we_r <= 1'b1; // [RULE13]
            wdata_r <= i_pm_data[7:0];
         end else if (t3 && exe && dec.wr_mem && !pcl_wr) begin
            we_r <= 1'b1; // [RULE12]
            wdata_r <= res;
         end else if (t4) begin
            we_r <= 1'b0;
         end
      end
   end

   // accumulator and flags settle at the end of the third phase
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         acc_r <= 8'h00;
         carry_r <= 1'b0;
         zero_r <= 1'b0;
      end else if (t3 && exe) begin
         if (dec.wr_acc) acc_r <= res; // [RULE15] [RULE7]
         if (dec.upd_z) zero_r <= (res == 8'h00); // [RULE8]
         if (dec.upd_c) carry_r <= alu_if.cout; // [RULE6] [RULE9]
      end
   end

   // global interrupt enable: the set beats a same-cycle clear
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         gie_r <= 1'b0;
      end else if (t4 && exe && op == OP_INT_RETURN) begin
         gie_r <= 1'b1; // [RULE16]
      end else if (i_gie_clr) begin
         gie_r <= 1'b0;
      end
   end

   assign o_pm_addr = pm_addr_r;
   assign o_dm_addr = dm_addr_r;
   assign o_dm_wdata = wdata_r;
   assign o_dm_we = we_r;
   assign o_acc = acc_r;
   assign o_carry = carry_r;
   assign o_zero = zero_r;
   assign o_gie = gie_r;
   assign o_halted = halt_r;
   assign o_icycle_end = t4;
   assign o_phase = ph_r;

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_jump;
      t4 && exe && op == OP_UNCOND_JUMP;
   endsequence
   sequence s_ret;
      t4 && exe && op == OP_SUB_RETURN;
   endsequence

   property p_icyc;
      (ph_r == PH_T1 && !halt_r) |-> ##3 t4 ##1 (ph_r == PH_T1);
   endproperty
   a_icyc: assert property (p_icyc) else $error("cycle not 4 clocks"); // [RULE3]
   property p_single;
      (t4 && exe && dec.wr_acc) |=> !flush_r && !tbl_r;
   endproperty
   a_single: assert property (p_single) else $error("extra cycle"); // [RULE1]
   property p_jump;
      s_jump |=> flush_r && o_pm_addr == $past(jtgt) ##4 !flush_r;
   endproperty
   a_jump: assert property (p_jump) else $error("jump flow"); // [RULE2] [RULE17]
   property p_pcl;
      (t4 && pcl_wr) |=> flush_r && o_pm_addr[7:0] == $past(res_r);
   endproperty
   a_pcl: assert property (p_pcl) else $error("pcl write no jump"); // [RULE4]
   property p_skip;
      (t4 && exe && op == OP_SKIP_ZERO) |=> flush_r == ($past(mdat_r) == 8'h00);
   endproperty
   a_skip: assert property (p_skip) else $error("skip timing"); // [RULE5] [RULE11]
   property p_carry;
      (t3 && exe && dec.aop == A_ADD) |=> o_carry == $past(add_cy);
   endproperty
   a_carry: assert property (p_carry) else $error("add carry"); // [RULE6]
   property p_zero;
      (t3 && exe && op inside {OP_AND, OP_OR, OP_XOR})
         |=> o_zero == ($past(res) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag"); // [RULE8]
   property p_bit;
      (t3 && exe && op == OP_BIT_SET && !pcl_wr)
         |=> o_dm_we && o_dm_wdata == ($past(mdat_r) | $past(mask));
   endproperty
   a_bit: assert property (p_bit) else $error("bit set"); // [RULE12]
   property p_inc;
      (t3 && exe && op == OP_INCREMENT && !pcl_wr)
         |=> o_dm_we && o_dm_wdata == $past(mdat_r) + 8'h01;
   endproperty
   a_inc: assert property (p_inc) else $error("increment"); // [RULE7]
   property p_ret;
      s_ret |=> flush_r && o_pm_addr == $past(top);
   endproperty
   a_ret: assert property (p_ret) else $error("return address"); // [RULE10]
   property p_interrupt_return;
      (t4 && exe && op == OP_INT_RETURN) |=> o_gie;
   endproperty
   a_interrupt_return: assert property (p_interrupt_return) else $error("gie not set"); // [RULE16]
   property p_halt;
      (t4 && exe && op == OP_HALT) |=> o_halted && ph_r == PH_T1;
   endproperty
   a_halt: assert property (p_halt) else $error("no halt"); // [RULE14]
endmodule : cie_core
